// ### core/rcs_selector.sv
`timescale 1ns/1ps
module rcs_selector
  import rcs_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [1:0]  cu_clk,
  input  wire logic [6:0]  lane_clk,
  input  wire logic [6:0]  lane_los,
  input  wire logic [1:0]  tenge_clk,
  input  wire logic [1:0]  pll_clk,
  input  wire logic [1:0]  pll_lock,
  output logic      [3:0]  line_clock_pin,
  output logic      [3:0]  line_clock_pin_en,
  output logic      [3:0]  dpll_ref_clk,
  output logic             first_pll_diff_output,
  output logic             second_pll_diff_output
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  rcs_cfg_t    cfg_ff     [RCS_NOUT];
  rcs_cfg_t    nxt_cfg    [RCS_NOUT];
  logic [1:0]  pllsq_ff,  nxt_pllsq;
  logic [1:0]  tgdiv_ff,  nxt_tgdiv;
  logic [6:0]  lanesq_ff, nxt_lanesq;
  logic [3:0]  pllout_ff, nxt_pllout;
  rcs_cu_t     cu_ff      [2];
  rcs_cu_t     nxt_cu     [2];
  logic [31:0] rdata_ff,  nxt_rdata;
  logic [31:0] status;
  logic [7:0]  sq_vec;
  logic [7:0]  act_vec;

  always_comb begin
    for (int i = 0; i < RCS_NOUT; i++) begin
      nxt_cfg[i] = cfg_ff[i];
    end
    nxt_pllsq  = pllsq_ff;
    nxt_tgdiv  = tgdiv_ff;
    nxt_lanesq = lanesq_ff;
    nxt_pllout = pllout_ff;
    nxt_cu[0]  = cu_ff[0];
    nxt_cu[1]  = cu_ff[1];
    nxt_rdata  = '0;
    status     = '0;
    status[STS_LOS_LSB +: 7]  = lane_los;
    status[STS_LOCK_LSB +: 2] = pll_lock;
    status[STS_SQ_LSB +: 8]   = sq_vec;
    status[STS_ACT_LSB +: 8]  = act_vec;
    if (reg_wr) begin
      if (reg_addr < OFS_PLL_CFG) begin
        nxt_cfg[reg_addr[2:0]] = rcs_cfg_t'(reg_wdata[8:0]);
      end
      case (reg_addr)
        OFS_PLL_CFG:     nxt_pllsq[0] = reg_wdata[0];
        OFS_PLL_CFG + 1: nxt_pllsq[1] = reg_wdata[0];
        OFS_TG_CFG:      nxt_tgdiv[0] = reg_wdata[0];
        OFS_TG_CFG + 1:  nxt_tgdiv[1] = reg_wdata[0];
        OFS_LANE_SQ:     nxt_lanesq   = reg_wdata[6:0];
        OFS_PLL_OUT:     nxt_pllout   = reg_wdata[3:0];
        OFS_CU_CTRL:     nxt_cu[0]    = rcs_cu_t'(reg_wdata[3:0]);
        OFS_CU_CTRL + 1: nxt_cu[1]    = rcs_cu_t'(reg_wdata[3:0]);
        default: ;
      endcase
    end
    if (reg_rd) begin
      if (reg_addr < OFS_PLL_CFG) begin
        nxt_rdata = {23'h000000, cfg_ff[reg_addr[2:0]]};
      end else begin
        case (reg_addr)
          OFS_PLL_CFG:     nxt_rdata = {31'h00000000, pllsq_ff[0]};
          OFS_PLL_CFG + 1: nxt_rdata = {31'h00000000, pllsq_ff[1]};
          OFS_TG_CFG:      nxt_rdata = {31'h00000000, tgdiv_ff[0]};
          OFS_TG_CFG + 1:  nxt_rdata = {31'h00000000, tgdiv_ff[1]};
          OFS_LANE_SQ:     nxt_rdata = {25'h0000000, lanesq_ff};
          OFS_PLL_OUT:     nxt_rdata = {28'h0000000, pllout_ff};
          OFS_CU_CTRL:     nxt_rdata = {28'h0000000, cu_ff[0]};
          OFS_CU_CTRL + 1: nxt_rdata = {28'h0000000, cu_ff[1]};
          OFS_STATUS:      nxt_rdata = status;
          default:         nxt_rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < RCS_NOUT; i++) begin
        cfg_ff[i] <= CFG_RST;
      end
      pllsq_ff  <= '0;
      tgdiv_ff  <= '0;
      lanesq_ff <= '0;
      pllout_ff <= '0;
      cu_ff[0]  <= '0;
      cu_ff[1]  <= '0;
      rdata_ff  <= '0;
    end else begin
      cfg_ff    <= nxt_cfg;
      pllsq_ff  <= nxt_pllsq;
      tgdiv_ff  <= nxt_tgdiv;
      lanesq_ff <= nxt_lanesq;
      pllout_ff <= nxt_pllout;
      cu_ff     <= nxt_cu;
      rdata_ff  <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source sampling, 10G stretch and source vectors
  rcs_clk_t    smp_ff, prv_ff;
  logic [5:0]  tgcnt_ff [RCS_NTG];
  logic [5:0]  nxt_tgcnt [RCS_NTG];
  logic [1:0]  tgskip_ff, nxt_tgskip;
  logic [31:0] src_lvl, src_rise, src_sq;
  rcs_clk_t    rise;
  logic        cu_ok;

  always_comb begin
    rise       = smp_ff & ~prv_ff;
    src_lvl    = '0;
    src_rise   = '0;
    src_sq     = '0;
    nxt_tgskip = tgskip_ff;
    cu_ok      = 1'b0;
    for (int t = 0; t < RCS_NTG; t++) begin
      nxt_tgcnt[t] = tgcnt_ff[t];
      if (rise.tg[t]) begin
        nxt_tgcnt[t]  = (tgcnt_ff[t] == TG_SKIP_CNT) ? '0 : tgcnt_ff[t] + 6'h01;
        nxt_tgskip[t] = tgdiv_ff[t] && (tgcnt_ff[t] == TG_SKIP_CNT);
      end
      src_lvl[SRC_TG0 + t]  = smp_ff.tg[t] && !tgskip_ff[t] && !nxt_tgskip[t];
      src_rise[SRC_TG0 + t] = rise.tg[t] && !nxt_tgskip[t];
    end
    for (int d = 0; d < 2; d++) begin
      cu_ok = cu_ff[d].ena && (cu_ff[d].src_sel == d[0])
              && cu_ff[d].freq_sel && cu_ff[d].path_sel;
      src_lvl[SRC_CU0 + d]  = smp_ff.cu[d] && cu_ok;
      src_rise[SRC_CU0 + d] = rise.cu[d] && cu_ok;
    end
    for (int k = 0; k < RCS_NLANE; k++) begin
      src_lvl[SRC_LANE_BASE + k]  = smp_ff.lane[k];
      src_rise[SRC_LANE_BASE + k] = rise.lane[k];
      // Squelch bits 4:0 gig lanes, 6:5 six-gig lanes
      src_sq[SRC_LANE_BASE + k]   = lanesq_ff[k] && lane_los[k];
    end
    src_sq[SRC_SIX_BASE +: 2] = lanesq_ff[6:5] & lane_los[6:5];
    src_lvl[SRC_PLL0]  = smp_ff.pll[0];
    src_rise[SRC_PLL0] = rise.pll[0];
    src_sq[SRC_PLL0]   = pllsq_ff[0] && !pll_lock[0];
    src_lvl[SRC_PLL1]  = smp_ff.pll[1];
    src_rise[SRC_PLL1] = rise.pll[1];
    src_sq[SRC_PLL1]   = pllsq_ff[1] && !pll_lock[1];
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      smp_ff      <= '0;
      prv_ff      <= '0;
      tgcnt_ff[0] <= '0;
      tgcnt_ff[1] <= '0;
      tgskip_ff   <= '0;
    end else begin
      smp_ff    <= '{pll: pll_clk, tg: tenge_clk, lane: lane_clk, cu: cu_clk};
      prv_ff    <= smp_ff;
      tgcnt_ff  <= nxt_tgcnt;
      tgskip_ff <= nxt_tgskip;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output dividers with safe config hand-over
  rcs_cfg_t   act_ff  [RCS_NOUT];
  rcs_cfg_t   nxt_act [RCS_NOUT];
  logic [4:0] cnt_ff  [RCS_NOUT];
  logic [4:0] nxt_cnt [RCS_NOUT];
  logic [7:0] out_ff, nxt_out;
  logic [7:0] legal;
  logic [4:0] ratio   [RCS_NOUT];
  logic [4:0] nratio  [RCS_NOUT];
  logic [7:0] wrap;

  always_comb begin
    for (int i = 0; i < RCS_NOUT; i++) begin
      ratio[i]  = rcs_ratio(act_ff[i].div);
      nratio[i] = rcs_ratio(cfg_ff[i].div);
      // 125 MHz code refused on pin outputs
      legal[i]  = act_ff[i].ena && (ratio[i] != 5'h00)
                  && !(i < RCS_NPIN && act_ff[i].div == DIV_CODE_125);
      sq_vec[i] = legal[i] && src_sq[act_ff[i].src];
      act_vec[i] = legal[i];
      wrap[i]   = src_rise[act_ff[i].src] && (cnt_ff[i] == ratio[i] - 5'h01);
      nxt_act[i] = act_ff[i];
      nxt_cnt[i] = cnt_ff[i];
      nxt_out[i] = out_ff[i];
      if (!legal[i]) begin
        nxt_cnt[i] = '0;
        nxt_out[i] = 1'b0;
      end else if (sq_vec[i]) begin
        nxt_out[i] = out_ff[i];
      end else if (ratio[i] == 5'h01) begin
        // High only from a source edge, so a late hand-over gives no runt
        nxt_out[i] = out_ff[i] ? src_lvl[act_ff[i].src]
                               : src_rise[act_ff[i].src];
      end else if (src_rise[act_ff[i].src]) begin
        nxt_cnt[i] = wrap[i] ? 5'h00 : cnt_ff[i] + 5'h01;
        nxt_out[i] = nxt_cnt[i] < (ratio[i] >> 1);
      end
      // New settings only while low at a period boundary, idle or squelched
      if (cfg_ff[i] != act_ff[i] && (sq_vec[i] || (!out_ff[i] &&
          (!legal[i] || ratio[i] == 5'h01 || wrap[i])))) begin
        nxt_act[i] = cfg_ff[i];
        nxt_out[i] = 1'b0;
        nxt_cnt[i] = (nratio[i] == 5'h00) ? 5'h00 : nratio[i] - 5'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < RCS_NOUT; i++) begin
        act_ff[i] <= CFG_RST;
        cnt_ff[i] <= '0;
      end
      out_ff <= '0;
    end else begin
      act_ff <= nxt_act;
      cnt_ff <= nxt_cnt;
      out_ff <= nxt_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PLL differential outputs
  logic [1:0] pdo_ff, nxt_pdo;

  always_comb begin
    for (int p = 0; p < RCS_NPLL; p++) begin
      case (pllout_ff[2*p +: 2])
        PLLO_DIRECT: nxt_pdo[p] = smp_ff.pll[p];
        PLLO_HALF:   nxt_pdo[p] = rise.pll[p] ? !pdo_ff[p] : pdo_ff[p];
        PLLO_OFF:    nxt_pdo[p] = 1'b0;
        default:     nxt_pdo[p] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pdo_ff <= '0;
    end else begin
      pdo_ff <= nxt_pdo;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs: low half to pins, high half internal
  logic [3:0] pin_en_ff;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_en_ff <= '0;
    end else begin
      pin_en_ff <= legal[3:0];
    end
  end

  assign reg_rdata              = rdata_ff;
  assign line_clock_pin         = out_ff[3:0];
  assign line_clock_pin_en      = pin_en_ff;
  assign dpll_ref_clk           = out_ff[7:4];
  assign first_pll_diff_output  = pdo_ff[0];
  assign second_pll_diff_output = pdo_ff[1];

endmodule

// ### core/rcs_pkg.sv
package rcs_pkg;

  localparam int RCS_NOUT  = 8;
  localparam int RCS_NPIN  = 4;
  localparam int RCS_NLANE = 7;
  localparam int RCS_NPLL  = 2;
  localparam int RCS_NTG   = 2;

  // Register index map (word per index)
  localparam logic [4:0] OFS_CFG      = 5'h00; // 8 words
  localparam logic [4:0] OFS_PLL_CFG  = 5'h08; // 2 words
  localparam logic [4:0] OFS_TG_CFG   = 5'h0A; // 2 words
  localparam logic [4:0] OFS_LANE_SQ  = 5'h0C;
  localparam logic [4:0] OFS_PLL_OUT  = 5'h0D;
  localparam logic [4:0] OFS_CU_CTRL  = 5'h0E; // 2 words
  localparam logic [4:0] OFS_STATUS   = 5'h10;

  // Status field positions
  localparam int STS_LOS_LSB  = 0;
  localparam int STS_LOCK_LSB = 8;
  localparam int STS_SQ_LSB   = 16;
  localparam int STS_ACT_LSB  = 24;

  // Source codes
  localparam logic [4:0] SRC_CU0       = 5'h00;
  localparam logic [4:0] SRC_LANE_BASE = 5'h04;
  localparam logic [4:0] SRC_SIX_BASE  = 5'h09;
  localparam logic [4:0] SRC_PLL0      = 5'h0C;
  localparam logic [4:0] SRC_TG0       = 5'h0D;
  localparam logic [4:0] SRC_PLL1      = 5'h15;

  localparam logic [2:0] DIV_CODE_125 = 3'h6;
  localparam logic [5:0] TG_SKIP_CNT  = 6'h20; // drop 1 edge in 33

  localparam logic [1:0] PLLO_OFF    = 2'h0;
  localparam logic [1:0] PLLO_DIRECT = 2'h1;
  localparam logic [1:0] PLLO_HALF   = 2'h2;

  typedef struct packed {
    logic [4:0] src;
    logic [2:0] div;
    logic       ena;
  } rcs_cfg_t;

  typedef struct packed {
    logic path_sel;
    logic freq_sel;
    logic src_sel;
    logic ena;
  } rcs_cu_t;

  typedef struct packed {
    logic [1:0] pll;
    logic [1:0] tg;
    logic [6:0] lane;
    logic [1:0] cu;
  } rcs_clk_t;

  localparam rcs_cfg_t CFG_RST = '0;

  // Divider code to ratio; zero marks an unusable code
  function automatic logic [4:0] rcs_ratio(input logic [2:0] code);
    case (code)
      3'h0:    rcs_ratio = 5'h02;
      3'h1:    rcs_ratio = 5'h04;
      3'h2:    rcs_ratio = 5'h05;
      3'h3:    rcs_ratio = 5'h08;
      3'h4:    rcs_ratio = 5'h10;
      3'h5:    rcs_ratio = 5'h19;
      3'h6:    rcs_ratio = 5'h01;
      default: rcs_ratio = 5'h00;
    endcase
  endfunction

endpackage

// ### test/rcs_selector_properties.sv
`timescale 1ns/1ps
module rcs_selector_properties
  import rcs_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [4:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [6:0]  lane_los,
  input wire logic [1:0]  pll_clk,
  input wire logic [1:0]  pll_lock,
  input wire logic [3:0]  line_clock_pin,
  input wire logic [3:0]  line_clock_pin_en,
  input wire logic [3:0]  dpll_ref_clk,
  input wire logic        first_pll_diff_output
);
  logic [4:0] src_ff, nxt_src;
  logic [6:0] lsq_ff, nxt_lsq;
  logic [1:0] po_ff, nxt_po;
  logic       psq_ff, nxt_psq, sq0, off0;
  logic [2:0] li;

  // Shadow of the writes steering output 0 and the first PLL pin
  always_comb begin
    {nxt_src, nxt_lsq, nxt_po, nxt_psq} = {src_ff, lsq_ff, po_ff, psq_ff};
    if (reg_wr && reg_addr == OFS_CFG) nxt_src = reg_wdata[8:4];
    if (reg_wr && reg_addr == OFS_LANE_SQ) nxt_lsq = reg_wdata[6:0];
    if (reg_wr && reg_addr == OFS_PLL_OUT) nxt_po = reg_wdata[1:0];
    if (reg_wr && reg_addr == OFS_PLL_CFG) nxt_psq = reg_wdata[0];
    if (!rst_n) {nxt_src, nxt_lsq, nxt_po, nxt_psq} = '0;
  end
  always_ff @(posedge mclk) begin
    {src_ff, lsq_ff, po_ff, psq_ff} <= {nxt_src, nxt_lsq, nxt_po, nxt_psq};
  end
  assign li   = 3'(src_ff - 5'h04);
  assign sq0  = (src_ff >= 5'h04 && src_ff <= 5'h0A && lsq_ff[li] && lane_los[li])
              || (src_ff == 5'h0C && psq_ff && !pll_lock[0]);
  assign off0 = (po_ff == PLLO_OFF) || (po_ff == 2'h3);

  ////////////////////////////////////////
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_squelched;
    sq0[*4];
  endsequence
  // Line clocks run at mclk/8, so no level may last under four cycles
  property p_no_runt(logic s);
    $changed(s) |=> $stable(s)[*3];
  endproperty

  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside read");
  a_cfg_reserved: assert property (reg_rd && reg_addr < OFS_PLL_CFG |=>
    reg_rdata[31:9] == 23'h0) else $error("config reserved bits set");
  a_unmapped_zero: assert property (reg_rd && reg_addr > OFS_STATUS |=>
    reg_rdata == 32'h0) else $error("unmapped read not zero");
  a_en_gates_pin: assert property ((line_clock_pin & ~line_clock_pin_en) == 4'h0)
    else $error("pin toggles while not selected");
  a_pin_no_runt: assert property (p_no_runt(line_clock_pin[0]))
    else $error("runt pulse on pin 0");
  a_dpll_no_runt: assert property (p_no_runt(dpll_ref_clk[0]))
    else $error("runt pulse on internal output 4");
  a_squelch_stop: assert property (s_squelched |-> $stable(line_clock_pin[0]))
    else $error("squelched output still toggles");
  a_pll_off_low: assert property (off0[*3] |-> !first_pll_diff_output)
    else $error("disabled pll output not low");
  a_pll_direct: assert property (po_ff == PLLO_DIRECT && $rose(pll_clk[0]) |->
    ##[1:3] $rose(first_pll_diff_output)) else $error("pll direct edge missing");
endmodule

bind rcs_selector rcs_selector_properties u_rcs_selector_properties (
  .mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .lane_los, .pll_clk, .pll_lock, .line_clock_pin, .line_clock_pin_en,
  .dpll_ref_clk, .first_pll_diff_output);

// ### test/rcs_line_partner.sv
`timescale 1ns/1ps
module rcs_line_partner (
  input  wire logic       mclk,
  input  wire logic [6:0] los_force,
  input  wire logic [1:0] unlock_force,
  output logic      [1:0] cu_clk,
  output logic      [6:0] lane_clk,
  output logic      [6:0] lane_los,
  output logic      [1:0] tenge_clk,
  output logic      [1:0] pll_clk,
  output logic      [1:0] pll_lock
);
  logic [2:0] cnt_ff = 3'h0;
  logic [2:0] nxt_cnt;

  // Line clocks at mclk/8, slow enough to be sampled cleanly
  always_comb nxt_cnt = cnt_ff + 3'h1;
  always_ff @(posedge mclk) cnt_ff <= nxt_cnt;
  assign cu_clk    = {2{cnt_ff[2]}};
  assign lane_clk  = {7{cnt_ff[2]}};
  assign tenge_clk = {2{cnt_ff[2]}};
  assign pll_clk   = {2{cnt_ff[2]}};
  // A lost lane keeps its clock, so only squelch can stop the output
  assign lane_los  = los_force;
  assign pll_lock  = ~unlock_force;
endmodule

// ### test/rcs_selector_tb.sv
`timescale 1ns/1ps
module rcs_selector_tb;
  import rcs_pkg::*;
  logic        mclk, rst_n, reg_wr, reg_rd, first_pll_diff_output;
  logic        second_pll_diff_output;
  logic [4:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_val;
  logic [1:0]  cu_clk, tenge_clk, pll_clk, pll_lock, unlock_force;
  logic [6:0]  lane_clk, lane_los, los_force;
  logic [3:0]  line_clock_pin, line_clock_pin_en, dpll_ref_clk;
  logic [9:0]  obs;
  int          fail_count, compares, cyc, lo, hi;

  assign obs = {second_pll_diff_output, first_pll_diff_output,
                dpll_ref_clk, line_clock_pin};
  rcs_selector u_rcs_selector (
    .mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cu_clk, .lane_clk, .lane_los, .tenge_clk, .pll_clk, .pll_lock,
    .line_clock_pin, .line_clock_pin_en, .dpll_ref_clk,
    .first_pll_diff_output, .second_pll_diff_output);
  rcs_line_partner u_rcs_line_partner (
    .mclk, .los_force, .unlock_force, .cu_clk, .lane_clk, .lane_los,
    .tenge_clk, .pll_clk, .pll_lock);

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  ////////////////////////////////////////
  task automatic wrap_up;
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", w, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  task automatic rise(input int i, output int n);
    n = 0;
    while (obs[i] !== 1'b0 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    while (obs[i] !== 1'b1 && n < 300) begin
      @(posedge mclk);
      n++;
    end
  endtask
  task automatic measure(input int i, input int k);
    int n;
    rise(i, n);
    rise(i, n);
    lo = 999;
    hi = 0;
    repeat (k) begin
      rise(i, n);
      if (n < lo) lo = n;
      if (n > hi) hi = n;
    end
  endtask
  task automatic quiet(input int i, input string w);
    int   c;
    logic v;
    c = 0;
    repeat (24) @(posedge mclk);
    v = obs[i];
    repeat (64) begin
      @(posedge mclk);
      if (obs[i] !== v) c++;
    end
    chk(w, c, 0);
  endtask

  ////////////////////////////////////////
  task automatic t_regs;
    rd(5'h03);
    chk("cfg3 reset", rd_val, 32'h0);
    wr(5'h03, 32'hFFFF_FFFF);
    rd(5'h03);
    chk("cfg3", rd_val, 32'h0000_01FF);
    wr(5'h1F, 32'hFFFF_FFFF);
    rd(5'h1F);
    chk("unmapped", rd_val, 32'h0);
    wr(5'h03, 32'h0);
  endtask
  task automatic t_pin;
    wr(OFS_CFG, {23'h0, 5'h04, 3'h6, 1'b1});
    wr(5'h01, {23'h0, 5'h09, 3'h1, 1'b1});
    quiet(0, "pin0 code6");
    chk("pin en", line_clock_pin_en[1:0], 2'h2);
    measure(1, 2);
    chk("pin1 period", hi, 32);
  endtask
  task automatic t_div;
    int r [7] = '{2, 4, 5, 8, 16, 25, 1};
    for (int c = 0; c < 7; c++) begin
      wr(5'h04, {23'h0, 5'h04, c[2:0], 1'b1});
      measure(4, 2);
      chk("div period", {lo[15:0], hi[15:0]}, {2{16'(r[c] * 8)}});
    end
  endtask
  task automatic t_src;
    logic [4:0] s [11] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
                           5'h0A, 5'h0C, 5'h15, 5'h0D, 5'h0E};
    foreach (s[j]) begin
      wr(5'h05, {23'h0, s[j], 3'h0, 1'b1});
      measure(5, 2);
      chk("src period", hi, 16);
    end
    wr(OFS_TG_CFG, 32'h1);
    wr(5'h05, {23'h0, 5'h0D, 3'h0, 1'b1});
    measure(5, 20);
    chk("stretch", {lo[15:0], hi[15:0]}, {16'd16, 16'd24});
    wr(5'h05, {23'h0, 5'h01, 3'h0, 1'b1});
    quiet(5, "copper ungated");
    wr(OFS_CU_CTRL + 5'h1, 32'hF);
    measure(5, 2);
    chk("copper period", hi, 16);
  endtask
  task automatic t_sq;
    logic [4:0] s [5] = '{5'h04, 5'h08, 5'h09, 5'h0C, 5'h15};
    logic [6:0] l [5] = '{7'h01, 7'h10, 7'h20, 7'h00, 7'h00};
    logic [1:0] u [5] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
    wr(OFS_LANE_SQ, 32'h7F);
    wr(OFS_PLL_CFG, 32'h1);
    wr(OFS_PLL_CFG + 5'h1, 32'h1);
    foreach (s[j]) begin
      wr(OFS_CFG, {23'h0, s[j], 3'h1, 1'b1});
      measure(0, 1);
      los_force <= l[j];
      unlock_force <= u[j];
      quiet(0, "squelched");
      rd(OFS_STATUS);
      chk("status", {rd_val[16], rd_val[9:0]}, {1'b1, ~u[j], 1'b0, l[j]});
      los_force <= 7'h0;
      unlock_force <= 2'h0;
      measure(0, 1);
      chk("resumed", hi, 32);
    end
  endtask
  task automatic t_pll;
    wr(OFS_PLL_OUT, 32'h9);
    measure(8, 2);
    chk("pll direct", hi, 8);
    measure(9, 2);
    chk("pll half", hi, 16);
    wr(OFS_PLL_OUT, 32'h0);
    quiet(8, "pll off");
  endtask
  task automatic t_rest;
    int o [4] = '{2, 3, 6, 7};
    foreach (o[j]) begin
      wr(o[j][4:0], {23'h0, 5'h04, 3'h0, 1'b1});
      measure(o[j], 2);
      chk("output period", hi, 16);
    end
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {los_force, unlock_force, fail_count, compares, cyc} = '0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_pin();
    t_div();
    t_src();
    t_sq();
    t_pll();
    t_rest();
    wrap_up();
  end
endmodule
